// ---- rtl/mrp_defs.svh ----
// Function
// - An instruction may drop the processor from privileged into user mode any time; the code ignores i_go_user in a cycle that takes a fault or an entry.
// - Privileged mode is re-entered only through legal entries, legal interrupt vectors or faults.
// - User-mode illegal transfers or external control operations fault at once.
// - Privileged mode imposes no restriction on register writes; I/O start and external control still need the control role.
// - User-mode addresses get the relocation base added at execution time.
// - Relocation register holds a size field counting 1024-word blocks.
// - A relocated user reference outside the region faults instead of accessing memory.
// - Relocation register writes from user mode are rejected as mode violations.
// - Privileged references bypass relocation and are absolute over the whole range.
// - A 24-bit interval timer decrements by one every 16 microseconds.
// - Timer reaching zero requests an interrupt and keeps counting down.
// - The timer interrupt is held off while in privileged mode.
// - Loading the interval timer is allowed only in privileged mode.
// - Exactly one processor holds the control role; others work under it.
// - A non-control processor may not control the system or start I/O.
// - Each fault fetches the instruction pair at its fixed reserved location.
// - Mode violations are reported through the non-maskable command fault.
// - Relocated absolute addresses span up to 262,144 words.
`ifndef MRP_DEFS_SVH
`define MRP_DEFS_SVH

`define MRP_ADDR_W 18
`define MRP_SPACE_WORDS 262144
`define MRP_BLK_SHIFT 10
`define MRP_SIZE_W 9
`define MRP_TIMER_W 24
`define MRP_TICK_US 16
`define MRP_CLK_KHZ 20000
`define MRP_TICK_CYC ((`MRP_TICK_US * `MRP_CLK_KHZ) / 1000)

`define MRP_OFS_STATUS 12'h000
`define MRP_OFS_RELOC 12'h004
`define MRP_OFS_TIMER 12'h008
`define MRP_OFS_ENTRY 12'h00c

`define MRP_RELOC_BASE_LSB 0
`define MRP_RELOC_SIZE_LSB 18
`define MRP_ENTRY_BASE_LSB 0
`define MRP_ENTRY_CNT_LSB 18
`define MRP_ENTRY_CNT_W 8

`define MRP_FAULT_BASE 18'h00000
`define MRP_RELOC_RST 32'h0000_0000
`define MRP_TIMER_RST 24'hff_ffff
`define MRP_ENTRY_RST 32'h0040_0040

`endif

// ---- rtl/mrp_pkg.sv ----
package mrp_pkg;

    typedef enum logic
    {
        MRP_PRIV = 1'b0,
        MRP_USER = 1'b1
    } mrp_mode_t;

    typedef enum logic [1:0]
    {
        MRP_F_NONE = 2'h0,
        MRP_F_BOUNDS = 2'h1,
        MRP_F_COMMAND = 2'h2,
        MRP_F_TIMER = 2'h3
    } mrp_fault_t;

endpackage

// ---- rtl/mrp_core.sv ----
`timescale 1ns/1ps
`include "mrp_defs.svh"

module mrp_core #(
    parameter int ADDR_W = `MRP_ADDR_W,
    parameter int TIMER_W = `MRP_TIMER_W,
    parameter int TICK_CYC = `MRP_TICK_CYC
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    // APB slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // Processor side
    input wire logic i_role_ctrl,
    input wire logic i_go_user,
    input wire logic i_sys_call,
    input wire logic [7:0] i_sys_target,
    input wire logic i_irq_valid,
    input wire logic [7:0] i_irq_vector,
    input wire logic i_ext_ctrl,
    input wire logic i_io_start,
    input wire logic i_ref_valid,
    input wire logic i_ref_write,
    input wire logic [ADDR_W-1:0] i_ref_addr,
    // Memory and system side
    output logic o_mem_req,
    output logic o_mem_write,
    output logic [ADDR_W-1:0] o_mem_addr,
    output logic o_io_grant,
    output logic o_ext_grant,
    output logic o_fetch_valid,
    output logic o_fetch_fault,
    output logic [ADDR_W-1:0] o_fetch_addr,
    output logic [1:0] o_fault_code,
    output logic o_mode_user,
    output logic o_timer_pend
);

    // =========================================================
    // Elaboration checks
    // =========================================================
    if (ADDR_W != `MRP_ADDR_W)
    begin : g_chk_addr
        $error("mrp_core: address width must match the 262144-word space");
    end
    if (TIMER_W < 2 || TIMER_W > 32)
    begin : g_chk_timer
        $error("mrp_core: timer width out of range");
    end
    if (TICK_CYC < 1)
    begin : g_chk_tick
        $error("mrp_core: tick count must be at least one cycle");
    end

    localparam int TICK_W = (TICK_CYC > 1) ? $clog2(TICK_CYC) : 1;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYC - 1);
    localparam int CNT_W = `MRP_ENTRY_CNT_W;

    // =========================================================
    // State
    // =========================================================
    mrp_pkg::mrp_mode_t mode_q;
    mrp_pkg::mrp_mode_t mode_d;
    logic [ADDR_W-1:0] reloc_base_q;
    logic [`MRP_SIZE_W-1:0] reloc_size_q;
    logic [ADDR_W-1:0] entry_base_q;
    logic [CNT_W-1:0] entry_cnt_q;
    logic [TIMER_W-1:0] timer_q;
    logic [TICK_W-1:0] tick_q;
    logic pend_q;
    logic [1:0] last_fault_q;
    logic role_q;

    // =========================================================
    // APB decode
    // =========================================================
    wire is_user = (mode_q == mrp_pkg::MRP_USER);
    wire is_priv = ~is_user;
    wire apb_setup = i_psel & ~i_penable;
    wire apb_acc = i_psel & i_penable;
    wire hit_status = (i_paddr == `MRP_OFS_STATUS);
    wire hit_reloc = (i_paddr == `MRP_OFS_RELOC);
    wire hit_timer = (i_paddr == `MRP_OFS_TIMER);
    wire hit_entry = (i_paddr == `MRP_OFS_ENTRY);
    wire hit_any = hit_status | hit_reloc | hit_timer | hit_entry;
    wire hit_prot = hit_reloc | hit_timer | hit_entry;
    wire wr_acc = apb_acc & i_pwrite;
    wire wr_denied = wr_acc & hit_prot & is_user;
    wire wr_ok = wr_acc & hit_prot & is_priv;
    wire wr_reloc = wr_ok & hit_reloc;
    wire wr_timer = wr_ok & hit_timer;
    wire wr_entry = wr_ok & hit_entry;

    assign o_pready = 1'b1;
    assign o_pslverr = apb_acc & (~hit_any | wr_denied);

    wire [31:0] rd_status = {26'h0, last_fault_q, pend_q, role_q, 1'b0, is_user};
    wire [31:0] rd_reloc = {5'h0, reloc_size_q, reloc_base_q};
    wire [31:0] rd_timer = 32'(timer_q);
    wire [31:0] rd_entry = {6'h0, entry_cnt_q, entry_base_q};
    wire [31:0] rd_sel = hit_status ? rd_status :
                         hit_reloc ? rd_reloc :
                         hit_timer ? rd_timer :
                         hit_entry ? rd_entry : 32'h0;

    // =========================================================
    // Timer tick divider
    // =========================================================
    wire tick = (tick_q == TICK_LAST);
    wire [TICK_W-1:0] tick_d = tick ? '0 : tick_q + TICK_W'(1);
    wire [TIMER_W-1:0] timer_dec = timer_q - TIMER_W'(1);
    wire timer_zero = tick & (timer_q == TIMER_W'(1));
    wire [TIMER_W-1:0] timer_d = wr_timer ? i_pwdata[TIMER_W-1:0] :
                                 tick ? timer_dec : timer_q;

    // =========================================================
    // Relocation and bounds
    // =========================================================
    wire [ADDR_W:0] limit = {reloc_size_q, {`MRP_BLK_SHIFT{1'b0}}};
    wire [ADDR_W:0] abs_sum = {1'b0, i_ref_addr} + {1'b0, reloc_base_q};
    wire rel_over = ({1'b0, i_ref_addr} >= limit);
    wire abs_over = abs_sum[ADDR_W];
    wire ref_oob = i_ref_valid & is_user & (rel_over | abs_over);
    wire [ADDR_W-1:0] ref_abs = is_user ? abs_sum[ADDR_W-1:0] : i_ref_addr;

    // =========================================================
    // Entries and command faults
    // =========================================================
    wire call_legal = (i_sys_target < entry_cnt_q);
    wire irq_legal = (i_irq_vector < entry_cnt_q);
    wire call_bad = i_sys_call & is_user & ~call_legal;
    wire irq_take = i_irq_valid & irq_legal;
    wire ctrl_ok = is_priv & role_q;
    wire ext_bad = i_ext_ctrl & ~ctrl_ok;
    wire io_bad = i_io_start & ~ctrl_ok;
    wire cmd_flt = call_bad | ext_bad | io_bad | wr_denied;
    wire tmr_flt = is_user & (pend_q | timer_zero);
    wire flt_any = ref_oob | cmd_flt | tmr_flt;
    wire ref_go = i_ref_valid & ~ref_oob & ~flt_any;

    wire [1:0] flt_code = ref_oob ? 2'(mrp_pkg::MRP_F_BOUNDS) :
                          cmd_flt ? 2'(mrp_pkg::MRP_F_COMMAND) :
                          tmr_flt ? 2'(mrp_pkg::MRP_F_TIMER) :
                          2'(mrp_pkg::MRP_F_NONE);
    wire [ADDR_W-1:0] flt_addr = `MRP_FAULT_BASE + ADDR_W'({flt_code, 1'b0});
    wire call_go = i_sys_call & (is_priv | call_legal);
    wire [ADDR_W-1:0] call_addr = entry_base_q + ADDR_W'(i_sys_target);
    wire [ADDR_W-1:0] irq_addr = entry_base_q + ADDR_W'(i_irq_vector);
    wire entry_go = ~flt_any & (irq_take | call_go);
    wire [ADDR_W-1:0] entry_addr = irq_take ? irq_addr : call_addr;

    // Fault clears the pending timer request only when taken as a timer fault
    wire pend_clr = flt_any & ~ref_oob & ~cmd_flt;
    wire pend_d = timer_zero | (pend_q & ~pend_clr);

    // =========================================================
    // Mode next state
    // =========================================================
    always_comb
    begin
        mode_d = mode_q;
        case (mode_q)
            mrp_pkg::MRP_PRIV:
            begin
                if (i_go_user & ~flt_any & ~entry_go)
                begin
                    mode_d = mrp_pkg::MRP_USER;
                end
            end
            mrp_pkg::MRP_USER:
            begin
                if (flt_any | entry_go)
                begin
                    mode_d = mrp_pkg::MRP_PRIV;
                end
            end
            default:
            begin
                mode_d = mrp_pkg::MRP_PRIV;
            end
        endcase
    end

    // =========================================================
    // Registers
    // =========================================================
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            mode_q <= mrp_pkg::MRP_PRIV;
            tick_q <= '0;
            timer_q <= TIMER_W'(`MRP_TIMER_RST);
            pend_q <= 1'b0;
        end
        else
        begin
            mode_q <= mode_d;
            tick_q <= tick_d;
            timer_q <= timer_d;
            pend_q <= pend_d;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            reloc_base_q <= ADDR_W'(`MRP_RELOC_RST);
            reloc_size_q <= '0;
            entry_base_q <= ADDR_W'(`MRP_ENTRY_RST);
            entry_cnt_q <= CNT_W'(`MRP_ENTRY_RST >> `MRP_ENTRY_CNT_LSB);
        end
        else
        begin
            if (wr_reloc)
            begin
                reloc_base_q <= i_pwdata[`MRP_RELOC_BASE_LSB +: ADDR_W];
                reloc_size_q <= i_pwdata[`MRP_RELOC_SIZE_LSB +: `MRP_SIZE_W];
            end
            if (wr_entry)
            begin
                entry_base_q <= i_pwdata[`MRP_ENTRY_BASE_LSB +: ADDR_W];
                entry_cnt_q <= i_pwdata[`MRP_ENTRY_CNT_LSB +: CNT_W];
            end
        end
    end

    // Role strap registered every cycle after reset release
    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            role_q <= 1'b0;
        end
        else
        begin
            role_q <= i_role_ctrl;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_prdata <= '0;
            o_mem_req <= 1'b0;
            o_mem_write <= 1'b0;
            o_mem_addr <= '0;
            o_io_grant <= 1'b0;
            o_ext_grant <= 1'b0;
        end
        else
        begin
            if (apb_setup)
            begin
                o_prdata <= rd_sel;
            end
            o_mem_req <= ref_go;
            o_mem_write <= i_ref_write & ref_go;
            o_mem_addr <= ref_go ? ref_abs : o_mem_addr;
            o_io_grant <= i_io_start & ctrl_ok & ~flt_any;
            o_ext_grant <= i_ext_ctrl & ctrl_ok & ~flt_any;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_fetch_valid <= 1'b0;
            o_fetch_fault <= 1'b0;
            o_fetch_addr <= '0;
            o_fault_code <= 2'h0;
            last_fault_q <= 2'h0;
        end
        else
        begin
            o_fetch_valid <= flt_any | entry_go;
            o_fetch_fault <= flt_any;
            o_fetch_addr <= flt_any ? flt_addr : entry_go ? entry_addr : o_fetch_addr;
            o_fault_code <= flt_code;
            if (flt_any)
            begin
                last_fault_q <= flt_code;
            end
        end
    end

    assign o_mode_user = is_user;
    assign o_timer_pend = pend_q;

endmodule

// ---- bench/mrp_core_properties.sv ----
`timescale 1ns/1ps
module mrp_core_properties #(
    parameter int ADDR_W = 18
) (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic i_role_ctrl,
    input wire logic i_go_user,
    input wire logic i_sys_call,
    input wire logic i_irq_valid,
    input wire logic i_ext_ctrl,
    input wire logic i_io_start,
    input wire logic i_ref_valid,
    input wire logic [ADDR_W-1:0] i_ref_addr,
    input wire logic o_pslverr,
    input wire logic o_mem_req,
    input wire logic [ADDR_W-1:0] o_mem_addr,
    input wire logic o_io_grant,
    input wire logic o_ext_grant,
    input wire logic o_fetch_valid,
    input wire logic o_fetch_fault,
    input wire logic [ADDR_W-1:0] o_fetch_addr,
    input wire logic [1:0] o_fault_code,
    input wire logic o_mode_user
);
    // ====================
    // Properties
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_arst_n);
    wire logic quiet = !(i_sys_call | i_irq_valid | i_ref_valid | i_ext_ctrl | i_io_start);
    wire logic prot = i_paddr inside {12'h004, 12'h008, 12'h00c};
    property p_priv_abs;
        i_ref_valid && !o_mode_user && !i_ext_ctrl && !i_io_start
        |=> o_mem_req && o_mem_addr == $past(i_ref_addr);
    endproperty
    a_priv_abs: assert property (p_priv_abs) else $error("priv address relocated");
    property p_user_wr;
        i_psel && i_penable && i_pwrite && o_mode_user && prot |-> o_pslverr;
    endproperty
    a_user_wr: assert property (p_user_wr) else $error("user write accepted");
    property p_bnd;
        o_fetch_fault && o_fault_code == mrp_pkg::MRP_F_BOUNDS |-> !o_mem_req;
    endproperty
    a_bnd: assert property (p_bnd) else $error("bounds fault with access");
    property p_fetch_priv;
        o_fetch_valid |-> !o_mode_user;
    endproperty
    a_fetch_priv: assert property (p_fetch_priv) else $error("fetch in user mode");
    property p_tmr_held;
        o_fetch_fault && o_fault_code == mrp_pkg::MRP_F_TIMER |-> $past(o_mode_user);
    endproperty
    a_tmr_held: assert property (p_tmr_held) else $error("timer fault in priv");
    property p_pair;
        o_fetch_fault |-> o_fetch_addr == ADDR_W'(2 * o_fault_code);
    endproperty
    a_pair: assert property (p_pair) else $error("fault pair address wrong");
    // Role strap is registered, so the role seen is last cycle's pin level
    property p_role_io;
        i_io_start && !$past(i_role_ctrl) |=> o_fetch_fault && !o_io_grant;
    endproperty
    a_role_io: assert property (p_role_io) else $error("io granted without role");
    property p_go_user;
        i_go_user && !o_mode_user && quiet |=> o_mode_user;
    endproperty
    a_go_user: assert property (p_go_user) else $error("user mode not entered");
    property p_ext_user;
        o_mode_user && i_ext_ctrl |=> o_fetch_fault && !o_ext_grant && !o_mode_user;
    endproperty
    a_ext_user: assert property (p_ext_user) else $error("user ext ctrl no fault");
    c_bnd: cover property (o_fetch_fault && o_fault_code == mrp_pkg::MRP_F_BOUNDS);
    c_entry: cover property (o_fetch_valid && !o_fetch_fault);
    c_tmr: cover property (o_fetch_fault && o_fault_code == mrp_pkg::MRP_F_TIMER);
endmodule

bind mrp_core mrp_core_properties #(.ADDR_W(ADDR_W)) u_props (
    .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_role_ctrl(i_role_ctrl), .i_go_user(i_go_user),
    .i_sys_call(i_sys_call), .i_irq_valid(i_irq_valid), .i_ext_ctrl(i_ext_ctrl),
    .i_io_start(i_io_start), .i_ref_valid(i_ref_valid), .i_ref_addr(i_ref_addr),
    .o_pslverr(o_pslverr), .o_mem_req(o_mem_req), .o_mem_addr(o_mem_addr),
    .o_io_grant(o_io_grant), .o_ext_grant(o_ext_grant), .o_fetch_valid(o_fetch_valid),
    .o_fetch_fault(o_fetch_fault), .o_fetch_addr(o_fetch_addr),
    .o_fault_code(o_fault_code), .o_mode_user(o_mode_user)
);

// ---- bench/mrp_mem_model.sv ----
`timescale 1ns/1ps
module mrp_mem_model (
    input wire logic i_clk_sys,
    input wire logic i_arst_n,
    input wire logic i_req,
    input wire logic [17:0] i_addr,
    output logic [17:0] o_last_addr,
    output logic [7:0] o_req_cnt
);
    // ====================
    // Request capture, 18-bit word space
    always @(posedge i_clk_sys or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            o_last_addr <= 18'h00000;
            o_req_cnt <= 8'h00;
        end
        else if (i_req === 1'b1)
        begin
            o_last_addr <= i_addr;
            o_req_cnt <= o_req_cnt + 8'h01;
        end
    end
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/1ps
module tb;
    logic i_clk_sys = 0, i_arst_n = 0, i_psel = 0, i_penable = 0, i_pwrite = 0;
    logic [11:0] i_paddr = 0;
    logic [31:0] i_pwdata = 0, o_prdata, r;
    logic o_pready, o_pslverr, i_role_ctrl = 1, i_go_user = 0, i_sys_call = 0;
    logic i_irq_valid = 0, i_ext_ctrl = 0, i_io_start = 0, i_ref_valid = 0, i_ref_write = 0;
    logic [7:0] i_sys_target = 0, i_irq_vector = 0, cnt;
    logic [17:0] i_ref_addr = 0, o_mem_addr, o_fetch_addr, last;
    logic o_mem_req, o_mem_write, o_io_grant, o_ext_grant, o_fetch_valid, o_fetch_fault;
    logic [1:0] o_fault_code;
    logic o_mode_user, o_timer_pend, e;
    int err_count = 0, n_checks = 0;
    mrp_core #(.TICK_CYC(4)) DUT (
        .i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_psel(i_psel), .i_penable(i_penable),
        .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
        .o_pready(o_pready), .o_pslverr(o_pslverr), .i_role_ctrl(i_role_ctrl),
        .i_go_user(i_go_user), .i_sys_call(i_sys_call), .i_sys_target(i_sys_target),
        .i_irq_valid(i_irq_valid), .i_irq_vector(i_irq_vector), .i_ext_ctrl(i_ext_ctrl),
        .i_io_start(i_io_start), .i_ref_valid(i_ref_valid), .i_ref_write(i_ref_write),
        .i_ref_addr(i_ref_addr), .o_mem_req(o_mem_req), .o_mem_write(o_mem_write),
        .o_mem_addr(o_mem_addr), .o_io_grant(o_io_grant), .o_ext_grant(o_ext_grant),
        .o_fetch_valid(o_fetch_valid), .o_fetch_fault(o_fetch_fault),
        .o_fetch_addr(o_fetch_addr), .o_fault_code(o_fault_code), .o_mode_user(o_mode_user),
        .o_timer_pend(o_timer_pend));
    mrp_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_req(o_mem_req),
        .i_addr(o_mem_addr), .o_last_addr(last), .o_req_cnt(cnt));
    always #25 i_clk_sys = ~i_clk_sys;
    // ====================
    // Shared tasks
    task chk(input logic [31:0] g, input logic [31:0] x);
        n_checks++;
        if (g !== x)
        begin
            $display("[ERR] %0t got %h exp %h", $time, g, x);
            err_count++;
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_clk_sys);
        i_psel <= 1; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk_sys);
        i_penable <= 1;
        do @(posedge i_clk_sys); while (o_pready !== 1'b1);
        r = o_prdata;
        e = o_pslverr;
        i_psel <= 0; i_penable <= 0;
    endtask
    task ev(input logic [6:0] m, input logic [17:0] a, input logic [7:0] t);
        @(posedge i_clk_sys);
        {i_ref_write, i_go_user, i_sys_call, i_irq_valid, i_ext_ctrl, i_io_start, i_ref_valid} <= m;
        i_ref_addr <= a; i_sys_target <= t; i_irq_vector <= t;
        @(posedge i_clk_sys);
        {i_ref_write, i_go_user, i_sys_call, i_irq_valid, i_ext_ctrl, i_io_start, i_ref_valid} <= 0;
        #1;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ====================
    // Scenarios
    task t_reg;
        apb(0, 12'h000, 0); chk(r, 32'h0000_0004);
        apb(0, 12'h00c, 0); chk(r, 32'h0040_0040);
        apb(0, 12'h004, 0); chk(r, 0);
        apb(0, 12'h010, 0); chk(e, 1);
        apb(1, 12'h004, 32'h0008_0100); chk(e, 0);
        apb(0, 12'h004, 0); chk(r, 32'h0008_0100);
        $display("t_reg done");
    endtask
    task t_priv;
        ev(6'h01, 18'h3ffff, 0);
        chk({o_mem_req, o_mem_write, o_mem_addr}, {2'b10, 18'h3ffff});
        ev(6'h02, 0, 0); chk(o_io_grant, 1);
        ev(6'h04, 0, 0); chk(o_ext_grant, 1);
        $display("t_priv done");
    endtask
    task t_user;
        ev(6'h20, 0, 0); chk(o_mode_user, 1);
        ev(6'h01, 18'h00010, 0); chk(o_mem_addr, 18'h00110);
        ev(7'h41, 18'h007ff, 0);
        chk({o_mem_req, o_mem_write, o_mem_addr}, {2'b11, 18'h008ff});
        ev(6'h01, 18'h00800, 0); chk({o_mem_req, o_fetch_fault}, 2'b01);
        chk({o_mode_user, o_fetch_addr}, {1'b0, 18'h00002});
        #50; chk(last, 18'h008ff);
        chk(cnt, 8'h03);
        apb(1, 12'h004, 32'h000b_ff00);
        ev(6'h20, 0, 0);
        ev(6'h01, 18'h00200, 0);
        chk({o_mem_req, o_fetch_fault, o_fault_code}, 4'b0101);
        apb(1, 12'h004, 32'h0008_0100); chk(e, 0);
        $display("t_user done");
    endtask
    task t_cmd;
        ev(6'h20, 0, 0);
        apb(1, 12'h004, 0); chk(e, 1);
        #1; chk({o_fetch_fault, o_fault_code}, 3'b110);
        apb(0, 12'h000, 0); chk(r, 32'h0000_0024);
        apb(0, 12'h004, 0); chk(r, 32'h0008_0100);
        ev(6'h20, 0, 0); ev(6'h04, 0, 0);
        chk({o_fetch_fault, o_ext_grant, o_fetch_addr}, {2'b10, 18'h00004});
        ev(6'h20, 0, 0); ev(6'h10, 0, 8'd20); chk(o_fault_code, 2'h2);
        ev(6'h20, 0, 0); ev(6'h10, 0, 8'd3);
        chk({o_fetch_valid, o_fetch_fault, o_mode_user, o_fetch_addr}, {3'b100, 18'h43});
        ev(6'h20, 0, 0); ev(6'h08, 0, 8'd2);
        chk({o_mode_user, o_fetch_addr}, {1'b0, 18'h42});
        @(posedge i_clk_sys);
        i_role_ctrl <= 0;
        ev(6'h02, 0, 0); chk({o_fetch_fault, o_io_grant}, 2'b10);
        @(posedge i_clk_sys);
        i_role_ctrl <= 1;
        $display("t_cmd done");
    endtask
    task t_tmr;
        apb(1, 12'h008, 32'd100);
        repeat (20) @(posedge i_clk_sys);
        apb(0, 12'h008, 0); chk(r < 100 && r > 90, 1);
        apb(1, 12'h008, 32'd2);
        repeat (16) @(posedge i_clk_sys);
        #1; chk({o_timer_pend, o_mode_user, o_fetch_fault}, 3'b100);
        ev(6'h20, 0, 0);
        @(posedge i_clk_sys); #1;
        chk({o_fetch_fault, o_fault_code, o_fetch_addr}, {3'b111, 18'h6});
        apb(0, 12'h008, 0); chk(r > 32'h00ff_0000, 1);
        ev(6'h20, 0, 0); apb(1, 12'h008, 0); chk(e, 1);
        apb(0, 12'h008, 0); chk(r > 32'h00ff_0000, 1);
        $display("t_tmr done");
    endtask
    initial
    begin
        repeat (16) @(posedge i_clk_sys);
        i_arst_n <= 1;
        t_reg;
        t_priv;
        t_user;
        t_cmd;
        t_tmr;
        finish_test;
    end
    initial
    begin
        #1_000_000;
        err_count++;
        finish_test;
    end
endmodule
